// file: verilog/sdram_cmd_defines.svh
// constants for the sdram command and bank control block
`ifndef SDRAM_CMD_DEFINES_SVH
`define SDRAM_CMD_DEFINES_SVH
`define BANK_COUNT 8
`define ROW_WIDTH 12
`define COL_WIDTH 9
`define AP_BIT 8
`define MODE_SEL_MAIN 3'h0
`define MODE_SEL_EXT 3'h1
`define MODE_RESET 12'h000
`define EXT_MODE_RESET 12'h008
`define TERM_DUAL_VAL 2'h2
`define TERM_LSB 2
`define DLL_DIS_BIT 6
`define DLL_RESET_BIT 8
`define RAS_MIN_NS 35
`define CLK_PERIOD_NS 40
`define RAS_MIN_CYC ((`RAS_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_NS 15
`define RP_CYC ((`RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_WIDTH 8
`endif

// file: verilog/sdram_cmd_pkg.sv
// types shared by the sdram command and bank control block
package sdram_cmd_pkg;
	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS}
		cmd_t;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] bank;
		logic [11:0] addr;
	} cmd_bus_t;
	typedef struct packed {
		logic en;
		logic [2:0] bank;
		logic [8:0] col;
		logic [3:0] byte_en;
		logic [31:0] data;
	} wr_req_t;
endpackage : sdram_cmd_pkg

// file: verilog/sdram_bank.sv
// one bank: open row, timers and auto precharge
`timescale 1ns/1ns
`default_nettype none
`include "sdram_cmd_defines.svh"
module sdram_bank #(
	parameter int CW = `CNT_WIDTH
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst_b, // async reset
	input wire logic i_act, // activate this bank
	input wire logic [11:0] i_row, // row to open
	input wire logic i_pre, // explicit precharge
	input wire logic i_access, // read or write accepted
	input wire logic i_ap, // auto precharge with access
	input wire logic [CW-1:0] i_burst_cyc, // burst length in clocks
	output logic o_open, // row open
	output logic o_precharging, // precharge in progress
	output logic [11:0] o_row // open row
);
	logic [CW-1:0] ras_reg;
	logic [CW-1:0] rp_reg;
	logic [CW-1:0] burst_reg;
	logic ap_reg;
	logic start_pre;
	// ******************************************
	// precharge start: explicit ignored unless open
	// ******************************************
	assign start_pre = o_open && (i_pre ||
		(ap_reg && burst_reg == '0 && ras_reg == '0 && !i_access));
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_open <= 1'b0;
			o_row <= 12'h000;
		end else if (start_pre) begin
			o_open <= 1'b0;
		end else if (i_act && !o_open && !o_precharging) begin
			o_open <= 1'b1;
			o_row <= i_row;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) ras_reg <= '0;
		else if (i_act && !o_open) ras_reg <= CW'(`RAS_MIN_CYC);
		else if (ras_reg != '0) ras_reg <= ras_reg - 1'b1;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rp_reg <= '0;
			o_precharging <= 1'b0;
		end else if (start_pre) begin
			rp_reg <= CW'(`RP_CYC);
			o_precharging <= 1'b1;
		end else if (rp_reg > CW'(1)) begin
			rp_reg <= rp_reg - 1'b1;
		end else begin
			rp_reg <= '0;
			o_precharging <= 1'b0;
		end
	end
	// auto precharge waits until both the burst end and the row open time have passed
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ap_reg <= 1'b0;
			burst_reg <= '0;
		end else if (i_access && o_open) begin
			ap_reg <= i_ap;
			burst_reg <= i_burst_cyc;
		end else begin
			if (burst_reg != '0) burst_reg <= burst_reg - 1'b1;
			if (start_pre) ap_reg <= 1'b0;
		end
	end
	chk_ap_after_ras: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		($rose(o_precharging) && !$past(i_pre)) |-> $past(ras_reg) == '0)
		else $error("auto precharge before row open time");
	chk_pre_idle_nop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_pre && !o_open) |=> !$rose(o_precharging))
		else $error("precharge to idle bank acted");
endmodule : sdram_bank
`default_nettype wire

// file: verilog/sdram_cmd_ctrl.sv
// command decode, mode registers, banks, write masking and snoop termination
// Behaviour
// - cs low decodes ras/cas/we into activate, read, write, precharge, refresh, load
// - cs high or nop starts nothing except the snoop termination disable; running operations continue
// - bank bits 00 load main mode register, 01 extended, others ignored
// - activate opens given row in selected bank until precharged
// - column from address 0-7 and 9; auto precharge bit per command
// - auto precharge closes row at burst end, else row stays open
// - write byte stored only when its mask bit is low
// - precharge closes one bank, or all banks when auto precharge bit high
// - precharge to idle or precharging bank is a no-operation
// - auto precharge starts earliest legal point, after row open time
// - refresh is auto with clock gate high, self refresh entry when low
// - self refresh disables loop and data pin termination; exit resets loop and restores
// - dual load termination turns off on any read, chip select ignored
// - termination off read_latency-1 clocks after read, for burst_len/2+2
// - snoop disable inactive in power-down or self refresh
// - termination on non-data pins always enabled
`timescale 1ns/1ns
`default_nettype none
`include "sdram_cmd_defines.svh"
module sdram_cmd_ctrl #(
	parameter int CW = `CNT_WIDTH
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst_b, // async reset, active low
	input wire logic i_cs_n, // chip select, active low
	input wire logic i_ras_n, // row strobe, active low
	input wire logic i_cas_n, // column strobe, active low
	input wire logic i_we_n, // write enable, active low
	input wire logic i_clk_gate_input, // clock enable pin
	input wire logic [2:0] i_bank_select_bits, // bank address
	input wire logic [11:0] i_addr, // address lines
	input wire logic [3:0] i_write_mask, // per byte, high masks
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wdata_valid, // write data beat present
	input wire logic [3:0] i_read_latency, // read latency in clocks
	input wire logic [3:0] i_burst_len, // burst length in beats
	input wire logic i_power_down, // device in power-down
	output logic [11:0] o_mode_reg, // main mode register
	output logic [11:0] o_ext_mode_reg, // extended mode register
	output logic [7:0] o_bank_open, // open row per bank
	output logic [7:0] o_bank_precharging, // precharge per bank
	output logic [11:0] o_open_row [8], // open row per bank
	output sdram_cmd_pkg::wr_req_t o_wr_req, // array write, bytes enabled
	output logic o_auto_refresh, // one refresh pulse
	output logic [11:0] o_refresh_row, // internal refresh row
	output logic o_self_refresh, // in self refresh
	output logic o_dll_enable, // loop enabled
	output logic o_dll_reset, // loop reset pulse
	output logic o_data_term_en, // data pin termination on
	output logic o_ctrl_term_en // non-data pin termination on
);
	logic [1:0] ras_sync;
	logic [1:0] cas_sync;
	logic [1:0] we_sync;
	logic [1:0] cs_sync;
	logic [1:0] cke_sync;
	sdram_cmd_pkg::cmd_bus_t cmd_reg;
	sdram_cmd_pkg::cmd_bus_t cmd_in;
	sdram_cmd_pkg::cmd_t cmd;
	logic snoop_rd;
	logic cke_q;
	logic [2:0] col_bank_reg;
	logic [8:0] col_reg;
	logic [CW-1:0] burst_cyc;
	logic [CW-1:0] wr_left_reg;
	logic [CW-1:0] odt_wait_reg;
	logic [CW-1:0] odt_off_reg;
	logic [7:0] act_v;
	logic [7:0] pre_v;
	logic [7:0] acc_v;
	logic is_rd;
	logic is_wr;
	// write beat pins {valid, mask, data}, synchronised like the strobes
	logic [36:0] wbeat_s1;
	logic [36:0] wbeat_s2;
	// ******************************************
	// pin synchronisers
	// ******************************************
	// pins come from outside the clock domain, so two flops before decode
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_sync <= 2'h3;
			ras_sync <= 2'h3;
			cas_sync <= 2'h3;
			we_sync <= 2'h3;
			cke_sync <= 2'h0;
			cmd_in <= '1;
			cmd_reg <= '1;
			wbeat_s1 <= 37'h0000000000;
			wbeat_s2 <= 37'h0000000000;
		end else begin
			cs_sync <= {cs_sync[0], i_cs_n};
			ras_sync <= {ras_sync[0], i_ras_n};
			cas_sync <= {cas_sync[0], i_cas_n};
			we_sync <= {we_sync[0], i_we_n};
			cke_sync <= {cke_sync[0], i_clk_gate_input};
			// address takes the same two flops so it lines up with the decoded strobes
			cmd_in <= {4'hF, i_bank_select_bits, i_addr};
			cmd_reg <= cmd_in;
			wbeat_s1 <= {i_wdata_valid, i_write_mask, i_wdata};
			wbeat_s2 <= wbeat_s1;
		end
	end
	// ******************************************
	// command decode
	// ******************************************
	always_comb begin
		cmd = sdram_cmd_pkg::CMD_NOP;
		if (!cs_sync[1]) begin
			unique case ({ras_sync[1], cas_sync[1], we_sync[1]})
				3'b011: cmd = sdram_cmd_pkg::CMD_ACT;
				3'b101: cmd = sdram_cmd_pkg::CMD_RD;
				3'b100: cmd = sdram_cmd_pkg::CMD_WR;
				3'b010: cmd = sdram_cmd_pkg::CMD_PRE;
				3'b001: cmd = sdram_cmd_pkg::CMD_REF;
				3'b000: cmd = sdram_cmd_pkg::CMD_MRS;
				default: cmd = sdram_cmd_pkg::CMD_NOP;
			endcase
		end
	end
	// snooping ignores chip select
	assign snoop_rd = ras_sync[1] && !cas_sync[1] && we_sync[1];
	assign is_rd = cmd == sdram_cmd_pkg::CMD_RD && !o_self_refresh;
	assign is_wr = cmd == sdram_cmd_pkg::CMD_WR && !o_self_refresh;
	// ******************************************
	// mode registers
	// ******************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mode_reg <= `MODE_RESET;
			o_ext_mode_reg <= `EXT_MODE_RESET;
		end else if (cmd == sdram_cmd_pkg::CMD_MRS) begin
			if (cmd_reg.bank == `MODE_SEL_MAIN) o_mode_reg <= cmd_reg.addr;
			else if (cmd_reg.bank == `MODE_SEL_EXT) o_ext_mode_reg <= cmd_reg.addr;
		end else if (o_mode_reg[`DLL_RESET_BIT]) begin
			o_mode_reg[`DLL_RESET_BIT] <= 1'b0;
		end
	end
	// ******************************************
	// banks
	// ******************************************
	assign burst_cyc = CW'({1'b0, i_burst_len[3:1]});
	genvar g;
	generate
		for (g = 0; g < `BANK_COUNT; g++) begin : g_bank
			assign act_v[g] = cmd == sdram_cmd_pkg::CMD_ACT && cmd_reg.bank == 3'(g);
			assign pre_v[g] = cmd == sdram_cmd_pkg::CMD_PRE &&
				(cmd_reg.addr[`AP_BIT] || cmd_reg.bank == 3'(g));
			assign acc_v[g] = (is_rd || is_wr) && cmd_reg.bank == 3'(g);
			sdram_bank #(.CW(CW)) u_bank (
				.i_ref_clk(i_ref_clk),
				.i_rst_b(i_rst_b),
				.i_act(act_v[g]),
				.i_row(cmd_reg.addr),
				.i_pre(pre_v[g]),
				.i_access(acc_v[g]),
				.i_ap(cmd_reg.addr[`AP_BIT]),
				.i_burst_cyc(burst_cyc),
				.o_open(o_bank_open[g]),
				.o_precharging(o_bank_precharging[g]),
				.o_row(o_open_row[g])
			);
		end
	endgenerate
	// ******************************************
	// write burst and byte masking
	// ******************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_left_reg <= '0;
			col_bank_reg <= 3'h0;
			col_reg <= 9'h000;
		end else if (is_wr) begin
			wr_left_reg <= CW'(i_burst_len);
			col_bank_reg <= cmd_reg.bank;
			col_reg <= {cmd_reg.addr[9], cmd_reg.addr[7:0]};
		end else if (wr_left_reg != '0 && wbeat_s2[36]) begin
			wr_left_reg <= wr_left_reg - 1'b1;
			col_reg <= col_reg + 9'h001;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wr_req <= '0;
		end else begin
			o_wr_req.en <= wr_left_reg != '0 && wbeat_s2[36];
			o_wr_req.bank <= col_bank_reg;
			o_wr_req.col <= col_reg;
			o_wr_req.byte_en <= ~wbeat_s2[35:32];
			o_wr_req.data <= wbeat_s2[31:0];
		end
	end
	// ******************************************
	// refresh, self refresh, loop
	// ******************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_auto_refresh <= 1'b0;
			o_refresh_row <= 12'h000;
			o_self_refresh <= 1'b0;
			o_dll_reset <= 1'b0;
			cke_q <= 1'b0;
		end else begin
			cke_q <= cke_sync[1];
			o_auto_refresh <= cmd == sdram_cmd_pkg::CMD_REF && cke_sync[1];
			o_dll_reset <= (o_self_refresh && cke_sync[1]) ||
				(cmd == sdram_cmd_pkg::CMD_MRS && cmd_reg.bank == `MODE_SEL_MAIN &&
				cmd_reg.addr[`DLL_RESET_BIT]);
			if (cmd == sdram_cmd_pkg::CMD_REF) o_refresh_row <= o_refresh_row + 12'h001;
			if (cmd == sdram_cmd_pkg::CMD_REF && !cke_sync[1]) o_self_refresh <= 1'b1;
			else if (cke_sync[1]) o_self_refresh <= 1'b0;
		end
	end
	assign o_dll_enable = !o_self_refresh && !o_ext_mode_reg[`DLL_DIS_BIT];
	assign o_ctrl_term_en = 1'b1;
	// ******************************************
	// snoop termination disable
	// ******************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			odt_wait_reg <= '0;
			odt_off_reg <= '0;
		end else if (o_self_refresh || i_power_down) begin
			odt_wait_reg <= '0;
			odt_off_reg <= '0;
		end else begin
			if (snoop_rd && o_ext_mode_reg[3:2] == `TERM_DUAL_VAL) begin
				odt_wait_reg <= CW'(i_read_latency) - CW'(1);
			end else if (odt_wait_reg > CW'(1)) begin
				odt_wait_reg <= odt_wait_reg - 1'b1;
			end else begin
				odt_wait_reg <= '0;
			end
			if (odt_wait_reg == CW'(1) || (snoop_rd && i_read_latency <= 4'h1 &&
				o_ext_mode_reg[3:2] == `TERM_DUAL_VAL))
				odt_off_reg <= burst_cyc + CW'(2);
			else if (odt_off_reg != '0)
				odt_off_reg <= odt_off_reg - 1'b1;
		end
	end
	assign o_data_term_en = odt_off_reg == '0 && !o_self_refresh;
	chk_term_sr_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_self_refresh |-> !o_data_term_en && !o_dll_enable && o_ctrl_term_en)
		else $error("termination or loop on during self refresh");
	chk_nop_no_open: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(cs_sync[1] && !o_bank_open[0]) |=> !o_bank_open[0] || $past(o_bank_open[0]))
		else $error("bank opened without command");
	chk_wr_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(wr_left_reg != '0 && wbeat_s2[36]) |=> o_wr_req.byte_en == ~$past(wbeat_s2[35:32]))
		else $error("write mask not honoured");
	chk_snoop_quiet_sr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(o_self_refresh || i_power_down) |=> odt_wait_reg == '0 && odt_off_reg == '0)
		else $error("snoop disable ran in power-down or self refresh");
endmodule : sdram_cmd_ctrl
`default_nettype wire

// file: testbench/ctrl_model.sv
// controller-side model driving the command, address and write data pins
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
	input wire logic i_ref_clk, // clock
	output logic o_cs_n, // chip select, active low
	output logic o_ras_n, // row strobe, active low
	output logic o_cas_n, // column strobe, active low
	output logic o_we_n, // write enable, active low
	output logic o_cke, // clock enable pin
	output logic [2:0] o_bank, // bank select
	output logic [11:0] o_addr, // address lines
	output logic [3:0] o_mask, // write mask
	output logic [31:0] o_wdata, // write data
	output logic o_wvalid // write beat strobe
);
	initial begin
		{o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} = 5'h1F;
		o_bank = 3'h0;
		o_addr = 12'h000;
		o_mask = 4'hF;
		o_wdata = 32'h00000000;
		o_wvalid = 1'b0;
	end
	// pins held for one edge: strobes and address share the same two-flop pipeline
	task automatic issue(input logic [2:0] rcw, input logic cs_n, input logic [2:0] b,
		input logic [11:0] a);
		@(posedge i_ref_clk);
		o_cs_n <= cs_n;
		{o_ras_n, o_cas_n, o_we_n} <= rcw;
		o_bank <= b;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_cs_n <= 1'b1;
		{o_ras_n, o_cas_n, o_we_n} <= 3'h7;
		// deselected lines carry no meaning, so they toggle rather than hold
		o_bank <= ~b;
		o_addr <= ~a;
		repeat (6) @(posedge i_ref_clk);
	endtask : issue
	// two back-to-back beats, valid held high between them
	task automatic beats(input logic [3:0] m0, input logic [3:0] m1, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_wvalid <= 1'b1;
		o_mask <= m0;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_mask <= m1;
		o_wdata <= ~d;
		@(posedge i_ref_clk);
		o_wvalid <= 1'b0;
		o_wdata <= d ^ 32'h5A5A5A5A;
		repeat (8) @(posedge i_ref_clk);
	endtask : beats
	// clock is kept running, so the gate may rise at once; only nops follow
	task automatic set_cke(input logic v);
		@(posedge i_ref_clk);
		o_cke <= v;
		repeat (20) @(posedge i_ref_clk);
	endtask : set_cke
endmodule : ctrl_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking testbench for the sdram command and bank control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, PRE = 3'h2, REF = 3'h1, MRS = 3'h0;
	logic clk, rst_b, cs_n, ras_n, cas_n, we_n, cke, wvalid, pdown;
	logic aref, sref, dll_en, dll_rst, dterm, cterm;
	logic [2:0] bank;
	logic [3:0] mask, rl, bl;
	logic [11:0] addr, mode, emode, refrow;
	logic [11:0] orow [8];
	logic [7:0] bopen, bpre;
	logic [31:0] wdata;
	logic [11:0] mvals [4] = '{12'h034, 12'h038, 12'hFFF, 12'hFFF};
	sdram_cmd_pkg::wr_req_t wr;
	sdram_cmd_pkg::wr_req_t wr_q [$];
	int bad_count = 0, cmp_count = 0, cyc = 0, low_cnt = 0, ar_cnt = 0, dr_cnt = 0, snap;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	ctrl_model m (.i_ref_clk(clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_we_n(we_n), .o_cke(cke), .o_bank(bank), .o_addr(addr), .o_mask(mask),
		.o_wdata(wdata), .o_wvalid(wvalid));
	sdram_cmd_ctrl dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_cs_n(cs_n), .i_ras_n(ras_n),
		.i_cas_n(cas_n), .i_we_n(we_n), .i_clk_gate_input(cke), .i_bank_select_bits(bank),
		.i_addr(addr), .i_write_mask(mask), .i_wdata(wdata), .i_wdata_valid(wvalid),
		.i_read_latency(rl), .i_burst_len(bl), .i_power_down(pdown), .o_mode_reg(mode),
		.o_ext_mode_reg(emode), .o_bank_open(bopen), .o_bank_precharging(bpre),
		.o_open_row(orow), .o_wr_req(wr), .o_auto_refresh(aref), .o_refresh_row(refrow),
		.o_self_refresh(sref), .o_dll_enable(dll_en), .o_dll_reset(dll_rst),
		.o_data_term_en(dterm), .o_ctrl_term_en(cterm));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	// ************************************************************
	// monitors and hang guard
	// ************************************************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dterm !== 1'b1) low_cnt <= low_cnt + 1;
		if (aref === 1'b1) ar_cnt <= ar_cnt + 1;
		if (dll_rst === 1'b1) dr_cnt <= dr_cnt + 1;
		if (wr.en === 1'b1) wr_q.push_back(wr);
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst_b = 1'b0;
		rl = 4'h4;
		bl = 4'h2;
		pdown = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk("ext mode reset", 32'h008, 32'(emode));
		chk("mode reset", 32'h000, 32'(mode));
		chk("dll enable", 32'h1, 32'(dll_en));
		chk("ctrl term", 32'h1, 32'(cterm));
		// banks 2 and 3 are reserved targets and must leave both registers alone
		for (int i = 0; i < 4; i++) begin
			m.issue(MRS, 1'b0, 3'(i), mvals[i]);
			chk("mode reg", 32'h034, 32'(mode));
			chk("ext mode reg", (i == 0) ? 32'h008 : 32'h038, 32'(emode));
		end
		m.issue(ACT, 1'b1, 3'h3, 12'hABC);
		chk("bank open deselected", 32'h00, 32'(bopen));
		m.issue(ACT, 1'b0, 3'h3, 12'hABC);
		chk("bank open", 32'h08, 32'(bopen));
		chk("open row", 32'hABC, 32'(orow[3]));
		m.issue(WR, 1'b0, 3'h3, 12'h2F5);
		m.beats(4'h5, 4'h0, 32'h11223344);
		chk("beats", 32'h2, 32'(wr_q.size()));
		if (wr_q.size() == 2) begin
			chk("beat0 col", 32'h1F5, 32'(wr_q[0].col));
			chk("beat0 bank", 32'h3, 32'(wr_q[0].bank));
			chk("beat0 bytes", 32'hA, 32'(wr_q[0].byte_en));
			chk("beat0 data", 32'h11223344, wr_q[0].data);
			chk("beat1 col", 32'h1F6, 32'(wr_q[1].col));
			chk("beat1 bytes", 32'hF, 32'(wr_q[1].byte_en));
			chk("beat1 data", 32'hEEDDCCBB, wr_q[1].data);
		end
		chk("row kept open", 32'h08, 32'(bopen));
		snap = low_cnt;
		m.issue(RD, 1'b1, 3'h0, 12'h000);
		repeat (4) @(posedge clk);
		chk("snoop off cycles", 32'(bl / 2 + 2), 32'(low_cnt - snap));
		@(posedge clk) pdown <= 1'b1;
		snap = low_cnt;
		m.issue(RD, 1'b1, 3'h0, 12'h000);
		repeat (4) @(posedge clk);
		chk("snoop in power-down", 32'h0, 32'(low_cnt - snap));
		@(posedge clk) pdown <= 1'b0;
		m.issue(RD, 1'b0, 3'h3, 12'h100);
		repeat (4) @(posedge clk);
		chk("auto precharge", 32'h00, 32'(bopen));
		m.issue(ACT, 1'b0, 3'h1, 12'h111);
		m.issue(ACT, 1'b0, 3'h2, 12'h222);
		m.issue(PRE, 1'b0, 3'h1, 12'h000);
		chk("single precharge", 32'h04, 32'(bopen));
		m.issue(PRE, 1'b0, 3'h5, 12'h000);
		chk("idle precharge", 32'h04, 32'(bopen));
		chk("idle precharging", 32'h00, 32'(bpre));
		m.issue(PRE, 1'b0, 3'h0, 12'h100);
		chk("all precharge", 32'h00, 32'(bopen));
		snap = ar_cnt;
		m.issue(REF, 1'b0, 3'h7, 12'hFFF);
		chk("auto refresh", 32'h1, 32'(ar_cnt - snap));
		chk("no self refresh", 32'h0, 32'(sref));
		m.set_cke(1'b0);
		m.issue(REF, 1'b0, 3'h0, 12'h000);
		chk("self refresh", 32'h1, 32'(sref));
		chk("dll off", 32'h0, 32'(dll_en));
		chk("data term off", 32'h0, 32'(dterm));
		chk("ctrl term kept", 32'h1, 32'(cterm));
		snap = dr_cnt;
		m.set_cke(1'b1);
		chk("self refresh exit", 32'h0, 32'(sref));
		chk("dll on", 32'h1, 32'(dll_en));
		chk("dll reset", 32'h1, 32'(dr_cnt - snap));
		chk("data term on", 32'h1, 32'(dterm));
		final_report();
	end
endmodule : tb_top
`default_nettype wire
